// ### pkg/esfp_pkg.sv
// constants for the engine status frame packer: payload layout, register map, states
// assumes one 50 MHz clock and an apb master with 32-bit data
// Operation
// RQ1 - byte 1 carries eight lamp demand bits; the code sends seven (i_lamp_dem) and puts the charge lamp in bit 8
// RQ2 - lamp bytes follow internal demands, not pins
// RQ3 - charge lamp on while charge sense low
// RQ4 - byte 2 preheat code, bits 3-8 zero
// RQ5 - bytes 3-4 hold eight two-bit protection fields
// RQ6 - fields: 01 active, 00 passive, 11 unavailable
// RQ7 - byte 5 bits 1-5 override flags
// RQ8 - byte 6 carries protection phase code
// RQ9 - phase codes 0,1,3,14,15 and 4-13
// RQ10 - byte 7 low nibble is running state
// RQ11 - byte 7 bit 8 set while fault active
// RQ12 - byte 7 bits 5-7 always zero
// RQ13 - byte 8 bits 1-2 stop-bus intent code
// RQ14 - on switch-off send once, bit 1 cleared
// RQ15 - byte 8 bit 8 selects data set
// RQ16 - byte 8 bits 3-7 sent as ones
// RQ17 - bit 1 is lsb, byte 1 first
package esfp_pkg;
  // payload field positions (bit 0 of the 64-bit word is byte 1 bit 1)
  localparam int LAMP_LSB = 0;
  localparam int CHG_BIT = 7;
  localparam int PRE_LSB = 8;
  localparam int PRE_PAD_LSB = 10;
  localparam int PROT_LSB = 16;
  localparam int OVR_LSB = 32;
  localparam int OVR_PAD_LSB = 37;
  localparam int PHASE_LSB = 40;
  localparam int RUN_LSB = 48;
  localparam int RUN_PAD_LSB = 52;
  localparam int FAULT_BIT = 55;
  localparam int STOP_LSB = 56;
  localparam int NA_LSB = 58;
  localparam int DSET_BIT = 63;
  // fixed fill values
  localparam logic [5:0] PRE_PAD = 6'h00;
  localparam logic [2:0] OVR_PAD = 3'h0;
  localparam logic [2:0] RUN_PAD = 3'h0;
  localparam logic [4:0] NA_FILL = 5'h1f;
  // stop-bus intent codes
  localparam logic [1:0] STOP_NONE = 2'h0;
  localparam logic [1:0] STOP_INTENT = 2'h1;
  localparam logic [1:0] STOP_DISABLED = 2'h3;
  // protection phase codes
  localparam logic [7:0] PH_NONE = 8'h00;
  localparam logic [7:0] PH_START_PROT = 8'h01;
  localparam logic [7:0] PH_WARN = 8'h03;
  localparam logic [7:0] PH_RUN_FIRST = 8'h04;
  localparam logic [7:0] PH_RUN_LAST = 8'h0d;
  localparam logic [7:0] PH_SHUTDOWN = 8'h0e;
  localparam logic [7:0] PH_DRV_STOP = 8'h0f;
  // register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_PERIOD = 8'h04;
  localparam logic [7:0] A_ISTAT = 8'h08;
  localparam logic [7:0] A_IMASK = 8'h0c;
  localparam logic [7:0] A_PAY_LO = 8'h10;
  localparam logic [7:0] A_PAY_HI = 8'h14;
  localparam logic [7:0] A_STATE = 8'h18;
  // reset values
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [2:0] IRQ_RST = 3'h0;
  localparam int IRQ_W = 3;
  // interrupt bit positions
  localparam int IRQ_SENT = 0;
  localparam int IRQ_HALT = 1;
  localparam int IRQ_FAULT = 2;
  // transmit states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEND = 3'b010,
    ST_HALT = 3'b100
  } esfp_state_type;
endpackage : esfp_pkg

// ### rtl/esfp_top.sv
// engine status frame packer: builds the periodic 8-byte status payload
// assumes status inputs come from logic on i_clk_sys, except i_charge_sense (a pin);
// the can transmit path takes o_tx_data when o_tx_valid and i_tx_ready are both high
//
// The address map and the APB interface to the registers were chosen for this implementation.
module esfp_top #(
  parameter int PERIOD_DEF = 5000  // default frame period in clock cycles, less one
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // engine controller status
  input wire logic [6:0] i_lamp_dem,
  input wire logic i_charge_sense,
  input wire logic [1:0] i_preheat,
  input wire logic [15:0] i_prot_fields,
  input wire logic [4:0] i_overrides,
  input wire logic [7:0] i_phase,
  input wire logic [3:0] i_run_state,
  input wire logic i_fault,
  input wire logic i_stop_intent,
  input wire logic i_switch_off,
  input wire logic i_test_dset,
  // can transmit path
  output logic [63:0] o_tx_data,
  output logic o_tx_valid,
  input wire logic i_tx_ready,
  output logic o_irq
);
  // charge sense synchroniser and filtered level
  logic chg_s1_q, chg_s2_q, chg_s3_q, chg_low_q;
  // registers
  logic [1:0] ctrl_q;  // bit0 enable, bit1 stop function disabled
  logic [31:0] period_q;  // one less than the cycles from one launch to the next
  logic [31:0] tmr_q;  // cycles since the last launch, less one
  logic [2:0] istat_q;  // sticky event flags, write one to clear
  logic [2:0] imask_q;  // which sticky flags reach the interrupt
  logic [2:0] ev_set;  // events of this cycle
  logic rdy_q;  // apb access already answered
  logic fault_q;  // fault level one cycle back, for the rising edge
  logic off_q;  // switch-off level one cycle back
  logic off_pend_q;  // switch-off frame still to be sent
  logic last_q;  // the frame on offer is the switch-off frame
  esfp_pkg::esfp_state_type st_q;  // frame state, one-hot

  // bus decode
  wire acc = i_psel & i_penable;
  wire wr_en = acc & rdy_q & i_pwrite;
  wire a_ctrl = (i_paddr == esfp_pkg::A_CTRL);
  wire a_per = (i_paddr == esfp_pkg::A_PERIOD);
  wire a_ist = (i_paddr == esfp_pkg::A_ISTAT);
  wire a_imk = (i_paddr == esfp_pkg::A_IMASK);
  wire a_plo = (i_paddr == esfp_pkg::A_PAY_LO);
  wire a_phi = (i_paddr == esfp_pkg::A_PAY_HI);
  wire a_st = (i_paddr == esfp_pkg::A_STATE);
  wire mapped = a_ctrl | a_per | a_ist | a_imk | a_plo | a_phi | a_st;

  // read mux
  wire [31:0] rd_mux =
    a_ctrl ? {30'h0, ctrl_q} :
    a_per ? period_q :
    a_ist ? {29'h0, istat_q} :
    a_imk ? {29'h0, imask_q} :
    a_plo ? o_tx_data[31:0] :
    a_phi ? o_tx_data[63:32] :
    a_st ? {28'h0, off_pend_q, st_q} : 32'h0;

  // stop-bus intent code
  wire [1:0] stop_code = ctrl_q[1] ? esfp_pkg::STOP_DISABLED :  // RQ13
    (i_stop_intent ? esfp_pkg::STOP_INTENT : esfp_pkg::STOP_NONE);
  // the switch-off frame clears bit 1 of the intent field
  wire [1:0] stop_tx = off_pend_q ? {stop_code[1], 1'b0} : stop_code;  // RQ14

  // live payload, byte 1 in the low bits (RQ17)
  wire [63:0] payload = {
    i_test_dset,  // RQ15
    esfp_pkg::NA_FILL,  // RQ16
    stop_tx,  // RQ13
    i_fault,  // RQ11
    esfp_pkg::RUN_PAD,  // RQ12
    i_run_state,  // RQ10
    i_phase,  // RQ8 RQ9
    esfp_pkg::OVR_PAD,
    i_overrides,  // RQ7
    i_prot_fields,  // RQ5 RQ6
    esfp_pkg::PRE_PAD,  // RQ4
    i_preheat,  // RQ4
    chg_low_q,  // RQ3
    i_lamp_dem  // RQ1 RQ2
  };

  // transmit control
  wire tmr_done = (tmr_q >= period_q);
  wire launch = (st_q == esfp_pkg::ST_IDLE) & ctrl_q[0] & (tmr_done | off_pend_q);
  wire accept = o_tx_valid & i_tx_ready;
  wire off_rise = i_switch_off & ~off_q;
  wire irq_d = |(istat_q & imask_q);

  // events that set sticky status bits
  assign ev_set[esfp_pkg::IRQ_SENT] = accept;
  assign ev_set[esfp_pkg::IRQ_HALT] = accept & last_q;
  assign ev_set[esfp_pkg::IRQ_FAULT] = i_fault & ~fault_q;

  // charge sense: three flops, change taken when second and third agree
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      chg_s1_q <= 1'b1;
      chg_s2_q <= 1'b1;
      chg_s3_q <= 1'b1;
      chg_low_q <= 1'b0;
    end else begin
      chg_s1_q <= i_charge_sense;
      chg_s2_q <= chg_s1_q;
      chg_s3_q <= chg_s2_q;
      if (chg_s2_q == chg_s3_q) begin
        chg_low_q <= ~chg_s3_q;  // RQ3
      end
    end
  end

  // apb answer: one wait cycle, then pready with registered data
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      rdy_q <= 1'b0;
      o_pready <= 1'b0;
      o_prdata <= 32'h0;
      o_pslverr <= 1'b0;
    end else begin
      rdy_q <= acc & ~rdy_q;
      o_pready <= acc & ~rdy_q;
      o_prdata <= (acc & ~rdy_q & ~i_pwrite) ? rd_mux : 32'h0;
      o_pslverr <= acc & ~rdy_q & ~mapped;
    end
  end

  // software registers
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      ctrl_q <= esfp_pkg::CTRL_RST;
      period_q <= PERIOD_DEF;
      imask_q <= esfp_pkg::IRQ_RST;
    end else if (wr_en) begin
      if (a_ctrl) begin
        ctrl_q <= i_pwdata[1:0];
      end
      if (a_per) begin
        period_q <= i_pwdata;
      end
      if (a_imk) begin
        imask_q <= i_pwdata[2:0];
      end
    end
  end

  // sticky status, write one to clear, set wins
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      istat_q <= esfp_pkg::IRQ_RST;
      o_irq <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      istat_q <= (istat_q & ~((wr_en & a_ist) ? i_pwdata[2:0] : 3'h0)) | ev_set;
      o_irq <= irq_d;
      fault_q <= i_fault;
    end
  end

  // switch-off request: caught on its rising edge, held until its frame goes
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      off_q <= 1'b0;
      off_pend_q <= 1'b0;
    end else begin
      off_q <= i_switch_off;
      if (off_rise & (st_q != esfp_pkg::ST_HALT)) begin
        off_pend_q <= 1'b1;
      end else if (launch) begin
        off_pend_q <= 1'b0;
      end
    end
  end

  // frame state machine: idle, offer frame, halt after switch-off frame
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      st_q <= esfp_pkg::ST_IDLE;
      tmr_q <= 32'h0;
      o_tx_valid <= 1'b0;
      o_tx_data <= 64'h0;
      last_q <= 1'b0;
    end else begin
      case (st_q)
        esfp_pkg::ST_IDLE: begin
          tmr_q <= tmr_done ? 32'h0 : tmr_q + 32'h1;
          if (launch) begin
            // payload frozen while offered
            o_tx_data <= payload;  // RQ2
            o_tx_valid <= 1'b1;
            last_q <= off_pend_q;  // RQ14
            st_q <= esfp_pkg::ST_SEND;
          end
        end
        esfp_pkg::ST_SEND: begin
          tmr_q <= tmr_q + 32'h1;
          if (accept) begin
            o_tx_valid <= 1'b0;
            // the switch-off frame is the final one
            if (last_q) begin
              st_q <= esfp_pkg::ST_HALT;  // RQ14
            end else begin
              st_q <= esfp_pkg::ST_IDLE;
            end
          end
        end
        esfp_pkg::ST_HALT: begin
          o_tx_valid <= 1'b0;  // RQ14
        end
        default: begin
          st_q <= esfp_pkg::ST_IDLE;
          o_tx_valid <= 1'b0;
        end
      endcase
    end
  end

  // checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  property p_lamp;
    launch |=> o_tx_data[esfp_pkg::LAMP_LSB +: 7] == $past(i_lamp_dem);
  endproperty
  a_lamp: assert property (p_lamp) else $error("lamp byte wrong");  // RQ1

  property p_charge;
    launch |=> o_tx_data[esfp_pkg::CHG_BIT] == $past(chg_low_q);
  endproperty
  a_charge: assert property (p_charge) else $error("charge lamp wrong");  // RQ3

  property p_chg_sync;
    (chg_s2_q == chg_s3_q) |=> chg_low_q == !$past(chg_s3_q);
  endproperty
  a_chg_sync: assert property (p_chg_sync) else $error("charge level stale");  // RQ3

  property p_pre;
    launch |=> o_tx_data[esfp_pkg::PRE_LSB +: 2] == $past(i_preheat)
      && o_tx_data[esfp_pkg::PRE_PAD_LSB +: 6] == esfp_pkg::PRE_PAD;
  endproperty
  a_pre: assert property (p_pre) else $error("preheat pad not zero");  // RQ4

  property p_prot;
    launch |=> o_tx_data[esfp_pkg::PROT_LSB +: 16] == $past(i_prot_fields)
      && o_tx_data[esfp_pkg::OVR_LSB +: 5] == $past(i_overrides);
  endproperty
  a_prot: assert property (p_prot) else $error("protection bytes wrong");  // RQ6

  property p_phase;
    launch |=> o_tx_data[esfp_pkg::PHASE_LSB +: 8] == $past(i_phase);
  endproperty
  a_phase: assert property (p_phase) else $error("phase byte wrong");  // RQ8

  property p_run;
    launch |=> o_tx_data[esfp_pkg::RUN_LSB +: 4] == $past(i_run_state)
      && o_tx_data[esfp_pkg::FAULT_BIT] == $past(i_fault);
  endproperty
  a_run: assert property (p_run) else $error("run or fault wrong");  // RQ11

  property p_pad;
    o_tx_valid |-> o_tx_data[esfp_pkg::RUN_PAD_LSB +: 3] == esfp_pkg::RUN_PAD
      && o_tx_data[esfp_pkg::NA_LSB +: 5] == esfp_pkg::NA_FILL;
  endproperty
  a_pad: assert property (p_pad) else $error("fill bits wrong");  // RQ16

  property p_disabled;
    launch && ctrl_q[1] |=> o_tx_data[esfp_pkg::STOP_LSB +: 2] == esfp_pkg::STOP_DISABLED
      || last_q;
  endproperty
  a_disabled: assert property (p_disabled) else $error("stop code wrong");  // RQ13

  property p_off;
    launch && off_pend_q |=> !o_tx_data[esfp_pkg::STOP_LSB] && last_q;
  endproperty
  a_off: assert property (p_off) else $error("switch-off bit set");  // RQ14

  property p_once;
    accept && last_q |=> !o_tx_valid [*8];
  endproperty
  a_once: assert property (p_once) else $error("frame after switch-off");  // RQ14

  property p_dset;
    launch |=> o_tx_data[esfp_pkg::DSET_BIT] == $past(i_test_dset);
  endproperty
  a_dset: assert property (p_dset) else $error("data set bit wrong");  // RQ15

  property p_irq;
    accept |=> istat_q[esfp_pkg::IRQ_SENT]
      ##1 (o_irq || !$past(imask_q[esfp_pkg::IRQ_SENT]));
  endproperty
  a_irq: assert property (p_irq) else $error("sent flag or irq wrong");

  // an offered frame stands unchanged until the can path takes it
  property p_hold;
    o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data);
  endproperty
  a_hold: assert property (p_hold) else $error("frame changed while offered");  // RQ2

  // pready answers for one cycle only, pslverr only comes with it
  property p_ready;
    o_pready |=> !o_pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready longer than one cycle");

  property p_err;
    o_pslverr |-> o_pready;
  endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");

  // once halted, no frame is offered again until reset
  property p_halt;
    st_q == esfp_pkg::ST_HALT |=> st_q == esfp_pkg::ST_HALT && !o_tx_valid;
  endproperty
  a_halt: assert property (p_halt) else $error("frame after halt");  // RQ14

  c_frame: cover property (launch ##[1:20] accept);
  c_off: cover property (off_rise ##[1:20] (accept && last_q));
  c_stall: cover property (o_tx_valid && !i_tx_ready ##1 accept);
  c_rd: cover property (o_pready && !o_pslverr);
  c_err: cover property (o_pready && o_pslverr);
endmodule : esfp_top

// ### sim/esfp_can_sink.sv
// can transmit path model: takes a payload whenever it is ready
// assumes one clock; i_slow makes it accept only one cycle in four
module esfp_can_sink (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_slow,
  output logic o_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt_q; // free running stall pattern
  // stall counter
  always_ff @(posedge i_clk_sys) begin
    cnt_q <= i_rst_b ? cnt_q + 2'h1 : 2'h0;
  end
  // ready is prompt, or slow when asked to stall
  always_ff @(posedge i_clk_sys) begin
    o_ready <= i_rst_b & (!i_slow | (cnt_q == 2'h3));
  end
endmodule : esfp_can_sink

// ### sim/engine_status_frame_packer_tb.sv
// self-checking bench for the status frame packer
// assumes esfp_pkg compiled first and the sink model beside it
module engine_status_frame_packer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk_sys = 0, i_rst_b = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic [7:0] i_paddr = 0, i_phase = 0;
  logic [31:0] i_pwdata = 0, o_prdata, rd;
  logic o_pready, o_pslverr, o_tx_valid, i_tx_ready, o_irq, er, slow = 0;
  logic [6:0] i_lamp_dem = 0;
  logic i_charge_sense = 1, i_fault = 0, i_stop_intent = 0, i_switch_off = 0;
  logic i_test_dset = 0;
  logic [1:0] i_preheat = 0, ctrl_m = 0;
  logic [15:0] i_prot_fields = 0, rnd = 16'h000d;
  logic [4:0] i_overrides = 0;
  logic [3:0] i_run_state = 0;
  logic [63:0] o_tx_data, last_exp;
  logic sw_m = 0, fault_seen = 0;
  int n_mismatch = 0, checked = 0, nfr = 0, k;
  logic [7:0] phs [15] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
    8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f};
  always #10 i_clk_sys = ~i_clk_sys;
  esfp_top #(.PERIOD_DEF(30)) DUT (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .o_prdata(o_prdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .i_lamp_dem(i_lamp_dem),
    .i_charge_sense(i_charge_sense),
    .i_preheat(i_preheat),
    .i_prot_fields(i_prot_fields),
    .i_overrides(i_overrides),
    .i_phase(i_phase),
    .i_run_state(i_run_state),
    .i_fault(i_fault),
    .i_stop_intent(i_stop_intent),
    .i_switch_off(i_switch_off),
    .i_test_dset(i_test_dset),
    .o_tx_data(o_tx_data),
    .o_tx_valid(o_tx_valid),
    .i_tx_ready(i_tx_ready),
    .o_irq(o_irq)
  );
  esfp_can_sink u_sink (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_slow(slow),
    .o_ready(i_tx_ready));
  // pseudo random source
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr
  // reference payload built from the live status inputs
  function automatic logic [63:0] expf(input logic off);
    logic [1:0] sc;
    sc = ctrl_m[1] ? 2'h3 : {1'h0, i_stop_intent};
    if (off) sc = sc & 2'h2;
    return {i_test_dset, 5'h1f, sc, i_fault, 3'h0, i_run_state, i_phase, 3'h0,
      i_overrides, i_prot_fields, 6'h00, i_preheat, ~i_charge_sense, i_lamp_dem};
  endfunction : expf
  task automatic cmp_frame(input string s, input logic [63:0] e, input logic [63:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : cmp_frame
  task automatic cmp_reg(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_frame(s, {32'h0, e}, {32'h0, g});
  endtask : cmp_reg
  task automatic cmp_flag(input string s, input logic e, input logic g);
    cmp_frame(s, {63'h0, e}, {63'h0, g});
  endtask : cmp_flag
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    i_psel <= 1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk_sys);
    i_penable <= 1;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 0;
    i_penable <= 0;
    if (n >= 20) cmp_flag("pready", 1, 0);
  endtask : apb
  task automatic rchk(input string s, input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    cmp_reg(s, e, rd);
  endtask : rchk
  // new status values right after a clock edge, random except preheat, phase and run state, which follow the step number
  task automatic set_in(input int i);
    logic [15:0] a, b, c;
    a = lfsr(rnd);
    b = lfsr(a);
    c = lfsr(b);
    rnd = c;
    @(posedge i_clk_sys);
    if (c[0] & !i_fault) fault_seen = 1;
    i_lamp_dem <= a[6:0];
    i_charge_sense <= a[7];
    i_preheat <= i[1:0];
    i_overrides <= a[14:10];
    i_prot_fields <= b;
    i_phase <= phs[i % 15];
    i_run_state <= 4'(i % 3);
    i_fault <= c[0];
    i_stop_intent <= c[1];
    i_test_dset <= c[2];
    slow <= c[3];
  endtask : set_in
  task automatic wait_frame;
    int n;
    n = 0;
    k = nfr;
    while (nfr == k && n < 500) begin
      @(posedge i_clk_sys);
      n++;
    end
    if (n >= 500) cmp_flag("frame sent", 1, 0);
  endtask : wait_frame
  // every accepted payload is compared with the reference
  always @(posedge i_clk_sys) begin
    if (o_tx_valid && i_tx_ready) begin
      last_exp = expf(sw_m);
      cmp_frame("payload", last_exp, o_tx_data);
      nfr++;
    end
  end
  task automatic end_sim;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  initial begin
    #200000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    repeat (3) @(posedge i_clk_sys);
    i_rst_b <= 1;
    rchk("ctrl", esfp_pkg::A_CTRL, 32'h0);
    rchk("period", esfp_pkg::A_PERIOD, 32'h1e);
    rchk("istat", esfp_pkg::A_ISTAT, 32'h0);
    apb(1, 8'h20, 32'hffffffff);
    cmp_flag("slverr", 1, er);
    rchk("unmapped", 8'h20, 32'h0);
    apb(1, esfp_pkg::A_PERIOD, 32'h14);
    apb(1, esfp_pkg::A_IMASK, 32'h1);
    set_in(0);
    apb(1, esfp_pkg::A_CTRL, 32'h1);
    ctrl_m = 1;
    for (int i = 1; i < 16; i++) begin
      wait_frame();
      if (i == 9) begin
        apb(1, esfp_pkg::A_CTRL, 32'h3);
        ctrl_m = 3;
      end
      set_in(i);
    end
    apb(1, esfp_pkg::A_CTRL, 32'h0);
    repeat (4) @(posedge i_clk_sys);
    cmp_flag("irq", 1, o_irq);
    rchk("istat", esfp_pkg::A_ISTAT, {29'h0, fault_seen, 2'h1});
    rchk("pay lo", esfp_pkg::A_PAY_LO, last_exp[31:0]);
    rchk("pay hi", esfp_pkg::A_PAY_HI, last_exp[63:32]);
    apb(1, esfp_pkg::A_IMASK, 32'h0);
    repeat (2) @(posedge i_clk_sys);
    cmp_flag("irq masked", 0, o_irq);
    apb(1, esfp_pkg::A_IMASK, 32'h3);
    apb(1, esfp_pkg::A_ISTAT, 32'h7);
    repeat (2) @(posedge i_clk_sys);
    cmp_flag("irq cleared", 0, o_irq);
    rchk("istat", esfp_pkg::A_ISTAT, 32'h0);
    // switch-off request while frames are off, then enable
    set_in(16);
    i_switch_off <= 1;
    sw_m = 1;
    repeat (2) @(posedge i_clk_sys);
    rchk("state", esfp_pkg::A_STATE, 32'h9);
    apb(1, esfp_pkg::A_CTRL, 32'h3);
    ctrl_m = 3;
    wait_frame();
    repeat (4) @(posedge i_clk_sys);
    cmp_flag("irq off", 1, o_irq);
    rchk("state", esfp_pkg::A_STATE, 32'h4);
    k = nfr;
    i_switch_off <= 0;
    repeat (3) @(posedge i_clk_sys);
    i_switch_off <= 1;
    repeat (80) @(posedge i_clk_sys);
    cmp_reg("frames after halt", 32'(k), 32'(nfr));
    end_sim();
  end
endmodule : engine_status_frame_packer_tb
